/* rtl/lel_regs.vh */
// register offsets, field positions and reset values of the line event latch
`ifndef LEL_REGS_VH
`define LEL_REGS_VH

// ----------------------------------------------------------------------------
// register offsets, channel 1 and channel 2
// ----------------------------------------------------------------------------
`define LEL_CH1_EVENT_FLAGS_A    8'h18
`define LEL_CH1_EVENT_FLAGS_B    8'h19
`define LEL_CH1_ERROR_COUNT_LOW  8'h1a
`define LEL_CH1_ERROR_COUNT_HIGH 8'h1b
`define LEL_CH2_EVENT_FLAGS_A    8'h38
`define LEL_CH2_EVENT_FLAGS_B    8'h39
`define LEL_CH2_ERROR_COUNT_LOW  8'h3a
`define LEL_CH2_ERROR_COUNT_HIGH 8'h3b

// ----------------------------------------------------------------------------
// field layout of event flags a (bits 7..5 reserved)
// ----------------------------------------------------------------------------
`define LEL_A_WIDTH               5
`define LEL_A_SIGNAL_LOSS_BIT     0
`define LEL_A_ALARM_SIGNAL_BIT    1
`define LEL_A_DRIVER_FAULT_BIT    2
`define LEL_A_TX_CLOCK_BIT        3
`define LEL_A_PATTERN_SYNC_BIT    4

// ----------------------------------------------------------------------------
// field layout of event flags b
// ----------------------------------------------------------------------------
`define LEL_B_WIDTH               8
`define LEL_B_COUNTER_WRAP_BIT    0
`define LEL_B_SECOND_TICK_BIT     1
`define LEL_B_CODE_VIOLATION_BIT  2
`define LEL_B_EXCESS_ZEROS_BIT    3
`define LEL_B_PATTERN_ERROR_BIT   4
`define LEL_B_JITTER_UNDER_BIT    5
`define LEL_B_JITTER_OVER_BIT     6
`define LEL_B_PULSE_AMP_OVER_BIT  7

// ----------------------------------------------------------------------------
// reset values and unmapped answer
// ----------------------------------------------------------------------------
`define LEL_FLAGS_RESET           8'h00
`define LEL_COUNT_RESET           8'h00
`define LEL_UNMAPPED_DATA         8'h00

`endif

/* rtl/lel_event_latch.v */
// dual-channel latched event status, interrupt request and error count readout
`timescale 1ns/1ps
`include "lel_regs.vh"

// ----------------------------------------------------------------------------
// Functional notes
// - reading flags a returns, clears, drops interrupt
// - reading flags b returns, clears, drops interrupt
// - flags a bit 4 latches pattern sync
// - flags a bit 3 latches transmit clock loss
// - flags a bit 2 latches driver fault
// - flags a bit 1 latches alarm signal
// - flags a bit 0 signal loss; 7..5 zero
// - flags b bit 7 latches pulse amplitude overflow
// - flags b bit 6 latches jitter buffer overflow
// - flags b bit 5 latches jitter buffer underflow
// - flags b bit 4 latches pattern error
// - flags b bit 3 latches excess zeros
// - flags b bit 2 latches code violation
// - flags b bit 1 latches one-second tick
// - flags b bit 0 latches counter wrap
// - count low register shows counter bits 7..0
// - count high register shows counter bits 15..8
// - edge select: rising only, or both edges
// - mask bit set keeps event off interrupt
// ----------------------------------------------------------------------------

module lel_event_latch #(
    parameter CHANNELS = 2,
    parameter CNT_W    = 16
) (
    // clock and reset
    input  wire                          CLK_SYS,
    input  wire                          SYS_RST,
    // control port read side
    input  wire                          RD_STB,
    input  wire [7:0]                    RD_ADDR,
    output reg  [7:0]                    RD_DATA,
    // real-time line status levels, 5 per channel (loss, alarm, fault, clock, sync)
    input  wire [CHANNELS*5-1:0]         LINE_STATUS,
    // trigger edge select per level source, 0 rising only, 1 both edges
    input  wire [CHANNELS*5-1:0]         EVENT_EDGE_SELECT,
    // one-cycle event pulses, 8 per channel in flags b bit order
    input  wire [CHANNELS*8-1:0]         EVENT_PULSE,
    // interrupt masks, flags a then flags b order, 1 masks
    input  wire [CHANNELS*5-1:0]         MASK_A,
    input  wire [CHANNELS*8-1:0]         MASK_B,
    // error counter value per channel
    input  wire [CHANNELS*CNT_W-1:0]     ERROR_COUNT,
    // interrupt request, active high level
    output reg                           IRQ
);

    // ------------------------------------------------------------------------
    // per-channel state and decode results
    // ------------------------------------------------------------------------
    wire [CHANNELS-1:0]   rd_a_hit;
    wire [CHANNELS-1:0]   rd_b_hit;
    wire [CHANNELS-1:0]   rd_lo_hit;
    wire [CHANNELS-1:0]   rd_hi_hit;
    wire [CHANNELS*8-1:0] flags_a_word;
    wire [CHANNELS*8-1:0] flags_b_word;
    wire [CHANNELS-1:0]   chan_pending;
    wire [CHANNELS*8-1:0] error_count_low_byte;
    wire [CHANNELS*8-1:0] error_count_high_byte;

    // channel base offsets; a channel's four registers sit at base + 0..3
    function [7:0] chan_base;
        input integer ch;
        begin
            chan_base = (ch == 0) ? `LEL_CH1_EVENT_FLAGS_A : `LEL_CH2_EVENT_FLAGS_A;
        end
    endfunction

    genvar gc;
    generate
        for (gc = 0; gc < CHANNELS; gc = gc + 1) begin : g_chan
            reg  [4:0]       status_prev_ff;
            reg  [4:0]       flags_a_ff;
            reg  [7:0]       flags_b_ff;
            wire [4:0]       status_now;
            wire [4:0]       edge_sel;
            wire [4:0]       level_event;
            wire [4:0]       nxt_flags_a;
            wire [7:0]       nxt_flags_b;
            wire [CNT_W-1:0] count_now;
            wire [7:0]       base;
            wire             signal_loss_event;
            wire             alarm_signal_event;
            wire             driver_fault_event;
            wire             tx_clock_missing_event;
            wire             pattern_sync_event;
            wire             counter_wrap_event;
            wire             second_tick_event;
            wire             code_violation_event;
            wire             excess_zeros_event;
            wire             pattern_error_event;
            wire             jitter_buffer_under_event;
            wire             jitter_buffer_over_event;
            wire             pulse_amplitude_overflow_event;
            wire [4:0]       set_a;
            wire [7:0]       set_b;

            assign base       = chan_base(gc);
            assign status_now = LINE_STATUS[gc*5 +: 5];
            assign edge_sel   = EVENT_EDGE_SELECT[gc*5 +: 5];
            assign count_now  = ERROR_COUNT[gc*CNT_W +: CNT_W];

            // counter bytes read live; no snapshot, so a moving counter can mix bytes
            assign error_count_low_byte[gc*8 +: 8]  = count_now[7:0];
            assign error_count_high_byte[gc*8 +: 8] = count_now[CNT_W-1 -: 8];

            // address decode for this channel
            assign rd_a_hit[gc]  = RD_STB & (RD_ADDR == base);
            assign rd_b_hit[gc]  = RD_STB & (RD_ADDR == (base + 8'h01));
            assign rd_lo_hit[gc] = RD_STB & (RD_ADDR == (base + 8'h02));
            assign rd_hi_hit[gc] = RD_STB & (RD_ADDR == (base + 8'h03));

            // rising edge always counts; falling edge only when edge select is set
            assign level_event = (status_now & ~status_prev_ff) |
                                 (edge_sel & (status_now ^ status_prev_ff));

            // named sources; level inputs follow flags a order, pulse inputs flags b order
            assign signal_loss_event              = level_event[`LEL_A_SIGNAL_LOSS_BIT];
            assign alarm_signal_event             = level_event[`LEL_A_ALARM_SIGNAL_BIT];
            assign driver_fault_event             = level_event[`LEL_A_DRIVER_FAULT_BIT];
            assign tx_clock_missing_event         = level_event[`LEL_A_TX_CLOCK_BIT];
            assign pattern_sync_event             = level_event[`LEL_A_PATTERN_SYNC_BIT];
            assign counter_wrap_event             = EVENT_PULSE[gc*8 + `LEL_B_COUNTER_WRAP_BIT];
            assign second_tick_event              = EVENT_PULSE[gc*8 + `LEL_B_SECOND_TICK_BIT];
            assign code_violation_event           = EVENT_PULSE[gc*8 + `LEL_B_CODE_VIOLATION_BIT];
            assign excess_zeros_event             = EVENT_PULSE[gc*8 + `LEL_B_EXCESS_ZEROS_BIT];
            assign pattern_error_event            = EVENT_PULSE[gc*8 + `LEL_B_PATTERN_ERROR_BIT];
            assign jitter_buffer_under_event      = EVENT_PULSE[gc*8 + `LEL_B_JITTER_UNDER_BIT];
            assign jitter_buffer_over_event       = EVENT_PULSE[gc*8 + `LEL_B_JITTER_OVER_BIT];
            assign pulse_amplitude_overflow_event = EVENT_PULSE[gc*8 + `LEL_B_PULSE_AMP_OVER_BIT];

            // set requests gathered back into register bit order
            assign set_a = {pattern_sync_event, tx_clock_missing_event, driver_fault_event,
                            alarm_signal_event, signal_loss_event};
            assign set_b = {pulse_amplitude_overflow_event, jitter_buffer_over_event,
                            jitter_buffer_under_event, pattern_error_event, excess_zeros_event,
                            code_violation_event, second_tick_event, counter_wrap_event};

            // clear on read, but a new event in the same cycle wins over the clear
            assign nxt_flags_a = (rd_a_hit[gc] ? 5'h00 : flags_a_ff) | set_a;
            assign nxt_flags_b = (rd_b_hit[gc] ? 8'h00 : flags_b_ff) | set_b;

            // status history and sticky flags
            always @(posedge CLK_SYS) begin
                if (SYS_RST) begin
                    status_prev_ff <= 5'h00;
                    flags_a_ff     <= 5'h00;
                    flags_b_ff     <= `LEL_FLAGS_RESET;
                end else begin
                    status_prev_ff <= status_now;
                    flags_a_ff     <= nxt_flags_a;
                    flags_b_ff     <= nxt_flags_b;
                end
            end

            // reserved bits 7..5 of flags a read as zero
            assign flags_a_word[gc*8 +: 8] = {3'h0, flags_a_ff};
            assign flags_b_word[gc*8 +: 8] = flags_b_ff;

            // masked sources never raise the request
            assign chan_pending[gc] = |(nxt_flags_a & ~MASK_A[gc*5 +: 5]) |
                                      |(nxt_flags_b & ~MASK_B[gc*8 +: 8]);
        end
    endgenerate

    // ------------------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------------------
    reg [7:0] nxt_rd_data;
    integer   ci;

    // unmapped addresses answer zero; only one channel can hit at a time
    always @* begin
        nxt_rd_data = `LEL_UNMAPPED_DATA;
        for (ci = 0; ci < CHANNELS; ci = ci + 1) begin
            if (rd_a_hit[ci]) begin
                nxt_rd_data = flags_a_word[ci*8 +: 8];
            end
            if (rd_b_hit[ci]) begin
                nxt_rd_data = flags_b_word[ci*8 +: 8];
            end
            if (rd_lo_hit[ci]) begin
                nxt_rd_data = error_count_low_byte[ci*8 +: 8];
            end
            if (rd_hi_hit[ci]) begin
                nxt_rd_data = error_count_high_byte[ci*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------------
    // read data holds until the next strobe so a slow host can sample it late
    always @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RD_DATA <= `LEL_COUNT_RESET;
            IRQ     <= 1'b0;
        end else begin
            if (RD_STB) begin
                RD_DATA <= nxt_rd_data;
            end
            IRQ <= |chan_pending;
        end
    end

endmodule

/* verification/lel_event_latch_props.sv */
// assertion checker for the line event latch ports
`timescale 1ns/1ps
module lel_event_latch_props #(parameter CHANNELS = 2, parameter CNT_W = 16) (
    // clock, reset and read port
    input wire                      CLK_SYS,
    input wire                      SYS_RST,
    input wire                      RD_STB,
    input wire [7:0]                RD_ADDR,
    input wire [7:0]                RD_DATA,
    // events, edge selects, masks, counter
    input wire [CHANNELS*5-1:0]     LINE_STATUS,
    input wire [CHANNELS*5-1:0]     EVENT_EDGE_SELECT,
    input wire [CHANNELS*8-1:0]     EVENT_PULSE,
    input wire [CHANNELS*5-1:0]     MASK_A,
    input wire [CHANNELS*8-1:0]     MASK_B,
    input wire [CHANNELS*CNT_W-1:0] ERROR_COUNT,
    input wire                      IRQ
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // quiet reads: no new event may sneak into the second answer
    sequence s_rd_a; RD_STB && RD_ADDR == 8'h18 && $stable(LINE_STATUS[4:0]) && !$past(SYS_RST); endsequence
    sequence s_rd_b; RD_STB && RD_ADDR == 8'h19 && EVENT_PULSE[7:0] == 8'h00; endsequence
    a_clear_flags_a: assert property (s_rd_a ##1 s_rd_a |=> RD_DATA == 8'h00) else $error("flags a kept");
    a_clear_flags_b: assert property (s_rd_b ##1 s_rd_b |=> RD_DATA == 8'h00) else $error("flags b kept");
    a_reserved_zero: assert property (RD_STB && RD_ADDR == 8'h38 |=> RD_DATA[7:5] == 3'h0)
        else $error("reserved set");
    a_count_low: assert property (RD_STB && RD_ADDR == 8'h3a |=> RD_DATA == $past(ERROR_COUNT[23:16]))
        else $error("count low wrong");
    a_count_high: assert property (RD_STB && RD_ADDR == 8'h1b |=> RD_DATA == $past(ERROR_COUNT[15:8]))
        else $error("count high wrong");
    a_wrap_irq: assert property (EVENT_PULSE[8] && !MASK_B[8] |=> IRQ) else $error("wrap no irq");
    a_rise_irq: assert property ($rose(LINE_STATUS[0]) && !MASK_A[0] |=> IRQ) else $error("rise no irq");
    a_fall_both_irq: assert property ($fell(LINE_STATUS[1]) && EVENT_EDGE_SELECT[1] && !MASK_A[1]
        && !$past(SYS_RST) |=> IRQ) else $error("fall no irq");
    a_irq_holds: assert property (IRQ && !RD_STB && $stable(MASK_A) && $stable(MASK_B) |=> IRQ)
        else $error("irq dropped");
    a_masked_quiet: assert property (&MASK_A && &MASK_B |=> !IRQ) else $error("masked irq");
endmodule
bind lel_event_latch lel_event_latch_props #(.CHANNELS(CHANNELS), .CNT_W(CNT_W)) props_u (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .RD_STB(RD_STB), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
    .LINE_STATUS(LINE_STATUS), .EVENT_EDGE_SELECT(EVENT_EDGE_SELECT), .EVENT_PULSE(EVENT_PULSE),
    .MASK_A(MASK_A), .MASK_B(MASK_B), .ERROR_COUNT(ERROR_COUNT), .IRQ(IRQ));

/* verification/lel_host_model.sv */
// host processor model issuing control port reads
`timescale 1ns/1ps
module lel_host_model (
    // clock
    input  wire       clk,
    // read request
    output reg        rd_stb = 1'b0,
    output reg  [7:0] rd_addr = 8'h00
);
    // one read a call; hold keeps the strobe up for a back-to-back read
    task rd(input [7:0] a, input hold);
        begin
            rd_stb = 1'b1;
            rd_addr = a;
            @(posedge clk);
            #1;
            if (!hold) begin
                rd_stb = 1'b0;
                rd_addr = ~a; // released address never shows a stale value
            end
        end
    endtask
endmodule

/* verification/lel_tb.sv */
// self-checking testbench of the line event latch
`timescale 1ns/1ps
module testbench;
    reg         clk_sys = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [9:0]  line_status = 10'h000;
    reg  [9:0]  edge_sel = 10'h000;
    reg  [15:0] pulse = 16'h0000;
    reg  [9:0]  mask_a = 10'h000;
    reg  [15:0] mask_b = 16'h0000;
    reg  [31:0] err_cnt = 32'h00000000;
    wire        rd_stb;
    wire [7:0]  rd_addr;
    wire [7:0]  rd_data;
    wire        irq;
    reg  [7:0]  exp_q[$];
    reg         seen;
    integer     fails = 0, n_tests = 0, cyc = 0, c, b, e;
    always #2.5 clk_sys = ~clk_sys;
    lel_host_model host_u (.clk(clk_sys), .rd_stb(rd_stb), .rd_addr(rd_addr));
    lel_event_latch dut_u (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .RD_STB(rd_stb), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .LINE_STATUS(line_status), .EVENT_EDGE_SELECT(edge_sel), .EVENT_PULSE(pulse),
        .MASK_A(mask_a), .MASK_B(mask_b), .ERROR_COUNT(err_cnt), .IRQ(irq));
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            if (fails == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task tick;
        begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    // note the expected answer, then let the host read
    task rx(input [7:0] a, input [7:0] x, input hold);
        begin
            exp_q.push_back(x);
            host_u.rd(a, hold);
        end
    endtask
    // answer lands one edge after the strobe; timeout cuts a hang short
    always @(posedge clk_sys) begin
        seen = rd_stb;
        #2;
        if (seen) chk(rd_data, exp_q.pop_front());
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            finish_test;
        end
    end
    initial begin
        e = $urandom(32'hc17847cb);
        err_cnt = $urandom;
        repeat (20) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        // every pulse source, read twice back to back
        for (c = 0; c < 2; c = c + 1) begin
            for (b = 0; b < 8; b = b + 1) begin
                pulse = 16'h0001 << (c * 8 + b);
                tick;
                pulse = 16'h0000;
                tick;
                chk({7'h00, irq}, 8'h01);
                rx(c ? 8'h39 : 8'h19, 8'h01 << b, 1'b1);
                rx(c ? 8'h39 : 8'h19, 8'h00, 1'b0);
                chk({7'h00, irq}, 8'h00);
            end
        end
        // every level source, rising only and both edges
        for (c = 0; c < 2; c = c + 1) begin
            for (b = 0; b < 5; b = b + 1) begin
                for (e = 0; e < 2; e = e + 1) begin
                    edge_sel[c * 5 + b] = e[0];
                    line_status[c * 5 + b] = 1'b1;
                    tick;
                    rx(c ? 8'h38 : 8'h18, 8'h01 << b, 1'b0);
                    line_status[c * 5 + b] = 1'b0;
                    tick;
                    rx(c ? 8'h38 : 8'h18, e ? (8'h01 << b) : 8'h00, 1'b0);
                end
            end
        end
        // mid-run reset drops a latched flag and the request
        pulse = 16'h0002;
        tick;
        pulse = 16'h0000;
        sys_rst = 1'b1;
        chk({7'h00, irq}, 8'h01);
        repeat (2) tick;
        sys_rst = 1'b0;
        chk({7'h00, irq}, 8'h00);
        rx(8'h19, 8'h00, 1'b0);
        tick;
        // all masked; event in the read cycle survives the clear
        mask_a = 10'h3ff;
        mask_b = 16'hffff;
        pulse = 16'h0100;
        rx(8'h39, 8'h00, 1'b1);
        pulse = 16'h0000;
        rx(8'h39, 8'h01, 1'b1);
        chk({7'h00, irq}, 8'h00);
        rx(8'h1a, err_cnt[7:0], 1'b1);
        rx(8'h1b, err_cnt[15:8], 1'b1);
        rx(8'h3a, err_cnt[23:16], 1'b1);
        rx(8'h3b, err_cnt[31:24], 1'b1);
        line_status[2] = 1'b1;
        rx(8'h18, 8'h00, 1'b1);
        rx(8'h18, 8'h04, 1'b1);
        rx(8'h18, 8'h00, 1'b1);
        rx(8'h40 | 8'($urandom), 8'h00, 1'b0);
        repeat (3) tick;
        finish_test;
    end
endmodule
